// ==== common/bftcra_pkg.sv ====
// constants and types for the framer control and alarm register bank
package bftcra_pkg;
    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_TX_FRAME_ERROR_CONFIG = 6'h29;
    localparam logic [5:0] IDX_E1_TX_FORMATTER_CONFIG = 6'h2a;
    localparam logic [5:0] IDX_RX_STATUS_SUMMARY = 6'h30;
    localparam logic [5:0] IDX_RX_ALARM_LIVE = 6'h31;
    localparam logic [5:0] IDX_E1_SYNC_LIVE = 6'h32;
    localparam logic [5:0] IDX_RX_ALARM_LATCHED = 6'h33;
    localparam logic [5:0] IDX_RX_INTERRUPT_ENABLE = 6'h34;
    localparam logic [5:0] IDX_LINE_MODE_CONFIG = 6'h3c;

    // reset values
    localparam logic [7:0] RST_TX_FRAME_ERROR_CONFIG = 8'h00;
    localparam logic [7:0] RST_E1_TX_FORMATTER_CONFIG = 8'h00;
    localparam logic [7:0] RST_RX_ALARM_LATCHED = 8'h00;
    localparam logic [7:0] RST_RX_INTERRUPT_ENABLE = 8'h00;
    localparam logic [7:0] RST_LINE_MODE_CONFIG = 8'h00;
    localparam logic [5:0] RST_CRC4_SYNC_COUNTER = 6'h00;

    // tx_frame_error_config fields
    localparam int BIT_TX_FRAMING_SELECT = 2;
    localparam int BIT_VIOLATION_INSERT = 1;

    // e1_tx_formatter_config fields
    localparam int BIT_TS0_PASS_THROUGH = 7;
    localparam int BIT_INTL_BIT_SOURCE = 4;
    localparam int BIT_TX_HDB3_ENABLE = 2;
    localparam int BIT_TX_ALARM_ALL_ONES = 1;
    localparam int BIT_TX_CRC4_ENABLE = 0;

    // rx_status_summary fields
    localparam int BIT_SUM_STATUS_FOUR = 6;
    localparam int BIT_SUM_STATUS_THREE = 1;
    localparam int BIT_SUM_STATUS_ONE = 0;

    // rx_alarm_live field positions; latched falls sit four above
    localparam int BIT_REMOTE_ALARM = 3;
    localparam int BIT_ALL_ONES_ALARM = 2;
    localparam int BIT_SIGNAL_LOSS = 1;
    localparam int BIT_FRAME_LOSS = 0;
    localparam int CLEAR_EVT_SHIFT = 4;

    // e1_sync_live fields
    localparam int BIT_FAS_SEARCH_ACTIVE = 2;
    localparam int BIT_CAS_MF_SEARCH_ACTIVE = 1;
    localparam int BIT_CRC4_MF_SEARCH_ACTIVE = 0;

    // line_mode_config fields
    localparam int BIT_TX_LINE_FORMAT_SELECT = 0;
    localparam int BIT_RX_LINE_FORMAT_SELECT = 1;
    localparam int BIT_RX_CRC4_ENABLE = 2;
    localparam int BIT_TX_BIT7_ZERO_SUPPRESS = 3;

    // channel byte position of transmitted bit 7 (bit 1 is the msb)
    localparam int CHAN_BIT7_POS = 1;
    localparam int CHAN_SI_POS = 7;
    localparam logic [7:0] ALL_ONES_BYTE = 8'hff;
    localparam logic [1:0] VIOLATION_RUN_ONES = 2'h3;

    // violation insertion states
    typedef enum logic [0:0] {
        BPV_IDLE = 1'b0,
        BPV_ARMED = 1'b1
    } bftcra_bpv_state_type;
endpackage

// ==== rtl/bftcra_regs.sv ====
// framer channel control, alarm and sync status registers with apb access
//
// Notes on behaviour
// - in 1.544 mode zero suppress on forces bit 7 high in all-zero channels; off, no stuffing.
// - in 1.544 mode framing bit 0 gives esf, 1 gives sf; unused in 2.048.
// - rising violation-insert bit arms one violation at next three consecutive ones.
// - 2.048 transmit config acts only when transmit format select is one.
// - pass-through on takes timeslot-0 bits from serial input, else from registers.
// - international bit select 0 takes Si from serial input, 1 from registers.
// - hdb3 enable bit turns transmit hdb3 line coding on or off.
// - transmit alarm bit sends unframed all ones instead of data.
// - crc-4 enable bit selects crc-4 multiframe framing for the formatter.
// - summary bits 6, 1, 0 flag unmasked status in status registers 4, 3, 1.
// - summary flag clears when no unmasked status remains; masked bits ignored.
// - live alarms: remote bit 3, all ones bit 2, signal loss 1, frame loss 0.
// - six-bit crc-4 sync counter counts search timeouts and wraps to zero.
// - sync counter clears on crc-4 multiframe sync or receive crc-4 disabled.
// - sync live bits 7..3 show counter bits 5,4,3,2,0; bit 1 hidden.
// - search flags read one while searching: fas bit 2, cas 1, crc-4 0.
// - 2.048 sync fields meaningful only in 2.048 receive mode.
// - latched bits 7..4 set on falling remote, all-ones, signal loss, frame loss.
// - latched bits clear only on written one; written zero leaves them.
// - set latched bit with its enable drives the interrupt request output.
// - latched bits 3..0 set on rising alarms and clear on written one.
// - enable register holds one enable per latched bit; 0 masks, 1 enables.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module bftcra_regs (
    input wire logic core_clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit channel stream
    input wire logic tx_chan_valid,
    input wire logic [7:0] tx_chan_data,
    input wire logic tx_chan_ts0,
    input wire logic tx_chan_nonalign,
    input wire logic [7:0] tx_serial_in,
    input wire logic [7:0] tx_align_word_reg,
    input wire logic [7:0] tx_nonalign_word_reg,
    output logic tx_out_valid,
    output logic [7:0] tx_out_data,
    // transmit line bits watched for violation placement
    input wire logic tx_line_bit_valid,
    input wire logic tx_line_bit,
    output logic tx_bpv_insert,
    // formatter mode outputs
    output logic tx_superframe,
    output logic tx_hdb3_enable,
    output logic tx_crc4_enable,
    output logic tx_alarm_all_ones,
    // receive framer live conditions
    input wire logic remote_alarm,
    input wire logic all_ones_alarm,
    input wire logic signal_loss,
    input wire logic frame_loss,
    input wire logic fas_search_active,
    input wire logic cas_mf_search_active,
    input wire logic crc4_mf_search_active,
    input wire logic crc4_search_timeout,
    input wire logic crc4_sync_achieved,
    input wire logic rx_status_reg_four_pending,
    input wire logic rx_status_reg_three_pending,
    output logic rx_crc4_enable,
    output logic interrupt_request_out
);
    logic [7:0] tx_frame_error_config;
    logic [7:0] e1_tx_formatter_config;
    logic [7:0] rx_alarm_latched;
    logic [7:0] rx_interrupt_enable_reg;
    logic [7:0] line_mode_config;
    logic [3:0] alarm_live;
    logic [5:0] crc4_sync_counter;
    logic [1:0] ones_run;
    logic violation_prev;
    bftcra_pkg::bftcra_bpv_state_type bpv_state;
    bftcra_pkg::bftcra_bpv_state_type next_bpv_state;
    logic [5:0] acc_index;
    logic wr_access;
    logic rd_setup;
    logic addr_mapped;
    logic [7:0] wbyte;
    logic e1_tx;
    logic e1_rx;
    logic zero_suppress;
    logic [3:0] alarm_now;
    logic [7:0] latch_set;
    logic [7:0] latch_clr;
    logic [7:0] rx_status_summary;
    logic [7:0] e1_sync_live;
    logic [7:0] read_mux;
    logic [7:0] ts0_byte;
    logic [7:0] next_tx_data;

    // bus decode
    assign acc_index = paddr[7:2];
    assign wbyte = pwdata[7:0];
    assign wr_access = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_mapped;

    // mode bits of the own configuration register
    assign e1_tx = line_mode_config[bftcra_pkg::BIT_TX_LINE_FORMAT_SELECT];
    assign e1_rx = line_mode_config[bftcra_pkg::BIT_RX_LINE_FORMAT_SELECT];
    assign rx_crc4_enable = line_mode_config[bftcra_pkg::BIT_RX_CRC4_ENABLE];
    assign zero_suppress = line_mode_config[bftcra_pkg::BIT_TX_BIT7_ZERO_SUPPRESS];

    // address map check
    always_comb begin
        case (acc_index)
            bftcra_pkg::IDX_TX_FRAME_ERROR_CONFIG,
            bftcra_pkg::IDX_E1_TX_FORMATTER_CONFIG,
            bftcra_pkg::IDX_RX_STATUS_SUMMARY,
            bftcra_pkg::IDX_RX_ALARM_LIVE,
            bftcra_pkg::IDX_E1_SYNC_LIVE,
            bftcra_pkg::IDX_RX_ALARM_LATCHED,
            bftcra_pkg::IDX_RX_INTERRUPT_ENABLE,
            bftcra_pkg::IDX_LINE_MODE_CONFIG: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    end

    // writable configuration registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_frame_error_config <= bftcra_pkg::RST_TX_FRAME_ERROR_CONFIG;
            e1_tx_formatter_config <= bftcra_pkg::RST_E1_TX_FORMATTER_CONFIG;
            rx_interrupt_enable_reg <= bftcra_pkg::RST_RX_INTERRUPT_ENABLE;
            line_mode_config <= bftcra_pkg::RST_LINE_MODE_CONFIG;
        end else if (wr_access) begin
            case (acc_index)
                bftcra_pkg::IDX_TX_FRAME_ERROR_CONFIG: begin
                    tx_frame_error_config <= wbyte & 8'h06;
                end
                bftcra_pkg::IDX_E1_TX_FORMATTER_CONFIG: begin
                    e1_tx_formatter_config <= wbyte & 8'h97;
                end
                bftcra_pkg::IDX_RX_INTERRUPT_ENABLE: begin
                    rx_interrupt_enable_reg <= wbyte;
                end
                bftcra_pkg::IDX_LINE_MODE_CONFIG: begin
                    line_mode_config <= wbyte & 8'h0f;
                end
                default: begin
                end
            endcase
        end
    end

    // formatter mode outputs
    // framing select
    assign tx_superframe = !e1_tx && tx_frame_error_config[bftcra_pkg::BIT_TX_FRAMING_SELECT];
    assign tx_hdb3_enable = e1_tx && e1_tx_formatter_config[bftcra_pkg::BIT_TX_HDB3_ENABLE];
    assign tx_crc4_enable = e1_tx && e1_tx_formatter_config[bftcra_pkg::BIT_TX_CRC4_ENABLE];
    assign tx_alarm_all_ones = e1_tx && e1_tx_formatter_config[bftcra_pkg::BIT_TX_ALARM_ALL_ONES];

    // timeslot-0 source selection
    always_comb begin
        ts0_byte = tx_chan_nonalign ? tx_nonalign_word_reg : tx_align_word_reg;
        if (!e1_tx_formatter_config[bftcra_pkg::BIT_INTL_BIT_SOURCE]) begin
            ts0_byte[bftcra_pkg::CHAN_SI_POS] = tx_serial_in[bftcra_pkg::CHAN_SI_POS];
        end
        if (e1_tx_formatter_config[bftcra_pkg::BIT_TS0_PASS_THROUGH]) begin
            ts0_byte = tx_serial_in;
        end
    end

    // outgoing channel byte
    always_comb begin
        next_tx_data = tx_chan_data;
        if (e1_tx) begin
            if (tx_chan_ts0) begin
                next_tx_data = ts0_byte;
            end
            if (tx_alarm_all_ones) begin
                next_tx_data = bftcra_pkg::ALL_ONES_BYTE;
            end
        end else if (zero_suppress && tx_chan_data == 8'h00) begin
            next_tx_data[bftcra_pkg::CHAN_BIT7_POS] = 1'b1;
        end
    end

    // registered channel output
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_out_valid <= 1'b0;
            tx_out_data <= 8'h00;
        end else begin
            tx_out_valid <= tx_chan_valid;
            if (tx_chan_valid) begin
                tx_out_data <= next_tx_data;
            end
        end
    end

    // violation arming: rising edge of the stored bit
    always_comb begin
        next_bpv_state = bpv_state;
        case (bpv_state)
            bftcra_pkg::BPV_IDLE: begin
                if (tx_frame_error_config[bftcra_pkg::BIT_VIOLATION_INSERT] && !violation_prev) begin
                    next_bpv_state = bftcra_pkg::BPV_ARMED;
                end
            end
            bftcra_pkg::BPV_ARMED: begin
                if (tx_line_bit_valid && tx_line_bit && ones_run == 2'h2) begin
                    next_bpv_state = bftcra_pkg::BPV_IDLE;
                end
            end
            default: next_bpv_state = bftcra_pkg::BPV_IDLE;
        endcase
    end

    // violation state, ones run and one-shot pulse
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bpv_state <= bftcra_pkg::BPV_IDLE;
            violation_prev <= 1'b0;
            ones_run <= 2'h0;
            tx_bpv_insert <= 1'b0;
        end else begin
            bpv_state <= next_bpv_state;
            violation_prev <= tx_frame_error_config[bftcra_pkg::BIT_VIOLATION_INSERT];
            tx_bpv_insert <= (bpv_state == bftcra_pkg::BPV_ARMED) && tx_line_bit_valid && tx_line_bit
                && ones_run == 2'h2;
            if (tx_line_bit_valid) begin
                if (!tx_line_bit || ones_run == bftcra_pkg::VIOLATION_RUN_ONES) begin
                    ones_run <= tx_line_bit ? 2'h1 : 2'h0;
                end else begin
                    ones_run <= ones_run + 2'h1;
                end
            end
        end
    end

    // live alarm capture
    // live conditions
    assign alarm_now = {remote_alarm, all_ones_alarm, signal_loss, frame_loss};
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            alarm_live <= 4'h0;
        end else begin
            alarm_live <= alarm_now;
        end
    end

    // edge events and write-one clears
    // falling edges high nibble
    assign latch_set = {alarm_live & ~alarm_now, ~alarm_live & alarm_now};
    assign latch_clr = (wr_access && acc_index == bftcra_pkg::IDX_RX_ALARM_LATCHED) ? wbyte : 8'h00;

    // latched alarm events
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rx_alarm_latched <= bftcra_pkg::RST_RX_ALARM_LATCHED;
        end else begin
            rx_alarm_latched <= (rx_alarm_latched & ~latch_clr) | latch_set;
        end
    end

    // interrupt request
    // enabled events request
    assign interrupt_request_out = |(rx_alarm_latched & rx_interrupt_enable_reg);

    // summary of status registers
    // summary flags
    always_comb begin
        rx_status_summary = 8'h00;
        rx_status_summary[bftcra_pkg::BIT_SUM_STATUS_ONE] = interrupt_request_out;
        rx_status_summary[bftcra_pkg::BIT_SUM_STATUS_THREE] = rx_status_reg_three_pending;
        rx_status_summary[bftcra_pkg::BIT_SUM_STATUS_FOUR] = rx_status_reg_four_pending;
    end

    // crc-4 sync counter
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            crc4_sync_counter <= bftcra_pkg::RST_CRC4_SYNC_COUNTER;
        end else if (!rx_crc4_enable || crc4_sync_achieved) begin
            crc4_sync_counter <= bftcra_pkg::RST_CRC4_SYNC_COUNTER;
        end else if (crc4_search_timeout) begin
            crc4_sync_counter <= crc4_sync_counter + 6'h01;
        end
    end

    // sync live view, zero outside 2.048 receive mode
    always_comb begin
        e1_sync_live = 8'h00;
        if (e1_rx) begin
            e1_sync_live[7:3] = {crc4_sync_counter[5:2], crc4_sync_counter[0]};
            e1_sync_live[bftcra_pkg::BIT_FAS_SEARCH_ACTIVE] = fas_search_active;
            e1_sync_live[bftcra_pkg::BIT_CAS_MF_SEARCH_ACTIVE] = cas_mf_search_active;
            e1_sync_live[bftcra_pkg::BIT_CRC4_MF_SEARCH_ACTIVE] = crc4_mf_search_active;
        end
    end

    // read multiplexer
    always_comb begin
        case (acc_index)
            bftcra_pkg::IDX_TX_FRAME_ERROR_CONFIG: read_mux = tx_frame_error_config;
            bftcra_pkg::IDX_E1_TX_FORMATTER_CONFIG: read_mux = e1_tx_formatter_config;
            bftcra_pkg::IDX_RX_STATUS_SUMMARY: read_mux = rx_status_summary;
            bftcra_pkg::IDX_RX_ALARM_LIVE: read_mux = {4'h0, alarm_live};
            bftcra_pkg::IDX_E1_SYNC_LIVE: read_mux = e1_sync_live;
            bftcra_pkg::IDX_RX_ALARM_LATCHED: read_mux = rx_alarm_latched;
            bftcra_pkg::IDX_RX_INTERRUPT_ENABLE: read_mux = rx_interrupt_enable_reg;
            bftcra_pkg::IDX_LINE_MODE_CONFIG: read_mux = line_mode_config;
            default: read_mux = 8'h00;
        endcase
    end

    // read data captured in the setup cycle, held through access
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= {24'h000000, read_mux};
        end
    end
endmodule
`default_nettype wire

// ==== verif/bftcra_regs_asserts.sv ====
// port checker for the framer register bank
`timescale 1ns/1ns
`default_nettype none
module bftcra_regs_asserts (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic tx_chan_valid,
    input wire logic [7:0] tx_out_data,
    input wire logic tx_line_bit_valid,
    input wire logic tx_line_bit,
    input wire logic tx_bpv_insert,
    input wire logic tx_superframe,
    input wire logic tx_hdb3_enable,
    input wire logic tx_crc4_enable,
    input wire logic tx_alarm_all_ones,
    input wire logic remote_alarm,
    input wire logic all_ones_alarm,
    input wire logic signal_loss,
    input wire logic frame_loss,
    input wire logic rx_status_reg_four_pending,
    input wire logic rx_status_reg_three_pending,
    input wire logic interrupt_request_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // read setups and completed writes
    wire logic rd_setup = psel && !penable && !pwrite;
    wire logic wr_done = psel && penable && pwrite;

    property p_bpv_cause; tx_bpv_insert |-> $past(tx_line_bit_valid && tx_line_bit); endproperty
    a_bpv_cause: assert property (p_bpv_cause) else $error("pulse without a one bit");
    property p_bpv_once; tx_bpv_insert |=> !tx_bpv_insert; endproperty
    a_bpv_once: assert property (p_bpv_once) else $error("violation pulse too long");
    property p_ais; tx_chan_valid && tx_alarm_all_ones |=> tx_out_data == bftcra_pkg::ALL_ONES_BYTE; endproperty
    a_ais: assert property (p_ais) else $error("alarm output not all ones");
    property p_mode; !(tx_superframe && (tx_hdb3_enable || tx_crc4_enable || tx_alarm_all_ones)); endproperty
    a_mode: assert property (p_mode) else $error("both line formats active");
    property p_live;
        rd_setup && paddr[7:2] == bftcra_pkg::IDX_RX_ALARM_LIVE
        |=> prdata == {28'h0, $past({remote_alarm, all_ones_alarm, signal_loss, frame_loss}, 2)};
    endproperty
    a_live: assert property (p_live) else $error("live alarm read wrong");
    property p_summary;
        rd_setup && paddr[7:2] == bftcra_pkg::IDX_RX_STATUS_SUMMARY
        |=> {prdata[6], prdata[1]} == $past({rx_status_reg_four_pending, rx_status_reg_three_pending});
    endproperty
    a_summary: assert property (p_summary) else $error("summary flags wrong");
    property p_irq_fall; $fell(interrupt_request_out) |-> $past(wr_done); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("request fell without write");
    property p_hdb3; $changed(tx_hdb3_enable) |-> $past(wr_done); endproperty
    a_hdb3: assert property (p_hdb3) else $error("line code changed alone");
    property p_crc4; $changed(tx_crc4_enable) |-> $past(wr_done); endproperty
    a_crc4: assert property (p_crc4) else $error("crc mode changed alone");

    // main scenarios seen
    c_bpv: cover property (tx_bpv_insert);
    c_irq: cover property ($rose(interrupt_request_out));
    c_ais: cover property (tx_chan_valid && tx_alarm_all_ones);
endmodule

bind bftcra_regs bftcra_regs_asserts bftcra_regs_asserts_inst (.core_clk, .reset, .psel, .penable, .pwrite,
    .paddr, .prdata, .tx_chan_valid, .tx_out_data, .tx_line_bit_valid, .tx_line_bit, .tx_bpv_insert,
    .tx_superframe, .tx_hdb3_enable, .tx_crc4_enable, .tx_alarm_all_ones, .remote_alarm, .all_ones_alarm,
    .signal_loss, .frame_loss, .rx_status_reg_four_pending, .rx_status_reg_three_pending, .interrupt_request_out);
`default_nettype wire

// ==== verif/bftcra_line_model.sv ====
// far-end line model: framer alarm levels and line bits
`timescale 1ns/1ns
`default_nettype none
module bftcra_line_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [3:0] alarm_cmd,
    input wire logic ones_on,
    output logic remote_alarm,
    output logic all_ones_alarm,
    output logic signal_loss,
    output logic frame_loss,
    output logic tx_line_bit_valid,
    output logic tx_line_bit
);
    // alarm levels follow the command a cycle late
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            {remote_alarm, all_ones_alarm, signal_loss, frame_loss} <= 4'h0;
        end else begin
            {remote_alarm, all_ones_alarm, signal_loss, frame_loss} <= alarm_cmd;
        end
    end
    // ones burst on request, else alternating bits
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_line_bit_valid <= 1'h0;
            tx_line_bit <= 1'h0;
        end else begin
            tx_line_bit_valid <= 1'h1;
            tx_line_bit <= ones_on | ~tx_line_bit;
        end
    end
endmodule
`default_nettype wire

// ==== verif/bftcra_regs_tb.sv ====
// self-checking bench for the framer register bank
`timescale 1ns/1ns
`default_nettype none
module bftcra_regs_tb;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, chan_v, chan_ts0, chan_na, out_v;
    logic ones_on, bpv, tmo, synced, fas, cas, crcs, pend4, pend3, sf, hdb3, crc4, ais, rcrc4, irq;
    logic lbv, lb, ra, aa, sl, fl, perr;
    logic [3:0] alarm_cmd;
    logic [7:0] paddr, chan_d, out_d, ser_in;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] rst_addr [6] = '{8'ha4, 8'ha8, 8'hc0, 8'hc4, 8'hc8, 8'hcc};
    int fails, tests_run, bpv_n;

    bftcra_regs bftcra_regs_inst (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tx_chan_valid(chan_v), .tx_chan_data(chan_d), .tx_chan_ts0(chan_ts0), .tx_chan_nonalign(chan_na),
        .tx_serial_in(ser_in), .tx_align_word_reg(8'h1b), .tx_nonalign_word_reg(8'h40), .tx_out_valid(out_v),
        .tx_out_data(out_d), .tx_line_bit_valid(lbv), .tx_line_bit(lb), .tx_bpv_insert(bpv), .tx_superframe(sf),
        .tx_hdb3_enable(hdb3), .tx_crc4_enable(crc4), .tx_alarm_all_ones(ais), .remote_alarm(ra),
        .all_ones_alarm(aa), .signal_loss(sl), .frame_loss(fl), .fas_search_active(fas), .cas_mf_search_active(cas),
        .crc4_mf_search_active(crcs), .crc4_search_timeout(tmo), .crc4_sync_achieved(synced),
        .rx_status_reg_four_pending(pend4), .rx_status_reg_three_pending(pend3), .rx_crc4_enable(rcrc4),
        .interrupt_request_out(irq));
    bftcra_line_model bftcra_line_model_inst (.core_clk, .reset, .alarm_cmd, .ones_on, .remote_alarm(ra),
        .all_ones_alarm(aa), .signal_loss(sl), .frame_loss(fl), .tx_line_bit_valid(lbv), .tx_line_bit(lb));

    // clock and violation pulse count
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (bpv === 1'h1) bpv_n++;

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'h0;
        @(posedge core_clk);
        penable <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) begin
            fails++;
            $display("FAIL %0t: no ready", $time);
            close_out;
        end
        r = prdata;
        perr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk(r, e);
    endtask
    // one channel byte; k is {ts0, nonalign}
    task automatic chan(input logic [7:0] d, input logic [1:0] k, input logic [7:0] e);
        @(posedge core_clk);
        chan_v <= 1'h1; chan_d <= d; {chan_ts0, chan_na} <= k;
        @(posedge core_clk);
        chan_v <= 1'h0;
        @(negedge core_clk);
        chk({out_v, out_d}, {1'h1, e});
    endtask
    task automatic burst;
        ones_on <= 1'h1;
        repeat (12) @(posedge core_clk);
        ones_on <= 1'h0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge core_clk) tmo <= 1'h1;
            @(posedge core_clk) tmo <= 1'h0;
        end
    endtask

    // hang guard
    initial begin
        repeat (40000) @(posedge core_clk);
        fails++;
        $display("FAIL %0t: run timed out", $time);
        close_out;
    end

    initial begin
        {psel, penable, pwrite, chan_v, chan_ts0, chan_na, ones_on, tmo, synced, fas, cas, crcs} = '0;
        {pend4, pend3, paddr, pwdata, chan_d, alarm_cmd} = '0;
        ser_in = 8'ha5; fails = 0; tests_run = 0; bpv_n = 0; reset = 1'h1;
        repeat (8) @(posedge core_clk);
        reset <= 1'h0;
        foreach (rst_addr[i]) rdc(rst_addr[i], 32'h0);
        rdc(8'h00, 32'h0);
        chk(perr, 32'h1);
        $display("test reset done");
        wr(8'ha4, 32'hff);
        rdc(8'ha4, 32'h06);
        chk(perr, 32'h0);
        chk(sf, 32'h1);
        wr(8'ha4, 32'h00);
        wr(8'hf0, 32'h08);
        chan(8'h00, 2'h0, 8'h02);
        chan(8'h81, 2'h0, 8'h81);
        wr(8'hf0, 32'h00);
        chan(8'h00, 2'h0, 8'h00);
        wr(8'hf0, 32'h01);
        wr(8'ha8, 32'h6f);
        rdc(8'ha8, 32'h07);
        @(negedge core_clk);
        chk({hdb3, ais, crc4, sf}, 32'he);
        chan(8'h00, 2'h0, 8'hff);
        wr(8'hf0, 32'h00);
        @(negedge core_clk);
        chk({hdb3, ais, crc4}, 32'h0);
        wr(8'hf0, 32'h01);
        wr(8'ha8, 32'h80);
        chan(8'h3c, 2'h2, 8'ha5);
        wr(8'ha8, 32'h10);
        chan(8'h3c, 2'h2, 8'h1b);
        chan(8'h3c, 2'h3, 8'h40);
        wr(8'ha8, 32'h00);
        chan(8'h3c, 2'h2, 8'h9b);
        $display("test transmit done");
        wr(8'ha4, 32'h02);
        burst;
        chk(bpv_n, 32'h1);
        burst;
        chk(bpv_n, 32'h1);
        wr(8'ha4, 32'h00);
        wr(8'ha4, 32'h02);
        burst;
        chk(bpv_n, 32'h2);
        $display("test violation done");
        wr(8'hd0, 32'h88);
        alarm_cmd <= 4'h8;
        repeat (4) @(posedge core_clk);
        rdc(8'hc4, 32'h08);
        rdc(8'hcc, 32'h08);
        chk(irq, 32'h1);
        rdc(8'hc0, 32'h01);
        alarm_cmd <= 4'h0;
        repeat (4) @(posedge core_clk);
        rdc(8'hcc, 32'h88);
        wr(8'hcc, 32'h00);
        rdc(8'hcc, 32'h88);
        wr(8'hcc, 32'h08);
        rdc(8'hcc, 32'h80);
        wr(8'hcc, 32'h80);
        @(negedge core_clk);
        chk(irq, 32'h0);
        alarm_cmd <= 4'h1;
        repeat (4) @(posedge core_clk);
        rdc(8'hcc, 32'h01);
        @(negedge core_clk);
        chk(irq, 32'h0);
        rdc(8'hc0, 32'h00);
        {pend4, pend3} <= 2'h3;
        rdc(8'hc0, 32'h42);
        // falling frame loss meets a same-cycle write-one clear
        fork
            wr(8'hcc, 32'h10);
            @(posedge core_clk) alarm_cmd <= 4'h0;
        join
        rdc(8'hcc, 32'h11);
        $display("test alarms done");
        wr(8'hf0, 32'h06);
        fas <= 1'h1;
        pulse(3);
        chk(rcrc4, 32'h1);
        rdc(8'hc8, 32'h0c);
        pulse(64);
        rdc(8'hc8, 32'h0c);
        @(posedge core_clk) synced <= 1'h1;
        @(posedge core_clk) synced <= 1'h0;
        rdc(8'hc8, 32'h04);
        pulse(4);
        rdc(8'hc8, 32'h14);
        wr(8'hf0, 32'h02);
        {fas, cas, crcs} <= 3'h3;
        rdc(8'hc8, 32'h03);
        chk(rcrc4, 32'h0);
        wr(8'hf0, 32'h00);
        rdc(8'hc8, 32'h00);
        $display("test sync done");
        close_out;
    end
endmodule
`default_nettype wire
